// File: hdl/dpc_regs.sv
// DPLL configuration register bank with Wishbone slave and loop state control.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Selection policy: field, pins, or automatic.
// - Manual select picks one of four inputs.
// - Feedback from external input or internal divider.
// - Revertive switching bit, reset zero.
// - Hitless switching bit, reset zero.
// - Acquire uses locking filter when switch set.
// - Lost reference goes holdover or freerun.
// - Sync group zero, one, or none.
// - Loop enable chooses attenuator or synthesizer.
// - Loop state forces free, auto, hold, write.
// - Switch decimator shift used only when hitless.
// - Decimator shift zero means feed-through.
// - Signed crystal trim, needs modulator order above zero.
// - Coarse hold shift clamped to twenty.
// - Fine hold multiplier zero disables filter.
// - History length zero to ten seconds.
// - Limit flag while loss count exceeds threshold.
// - Separate acquire and normal bandwidth, damping.
// - Acquire to normal after half lock timer.
module dpc_regs
  import dpc_pkg::*;
#(
  parameter int TIMER_W = 16
) (
  // Clock, reset and enable.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [4:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Pin and loop inputs.
  input wire logic [1:0] i_ref_pins,
  input wire logic i_auto_ref_valid,
  input wire logic [1:0] i_auto_ref,
  input wire logic i_ref_valid,
  input wire logic i_phase_ok,
  input wire logic [3:0] i_loss_count,
  input wire logic [TIMER_W-1:0] i_lock_timer,
  input wire logic i_timer_tick,
  input wire logic i_modulator_ok,
  // Configuration outputs to the loop.
  output logic [1:0] o_active_ref,
  output logic o_feedback_external,
  output logic o_feedback_divider_on,
  output logic o_revertive,
  output logic o_hitless,
  output logic [1:0] o_sync_group,
  output logic o_sync_none,
  output logic o_filter_update_off,
  output logic o_loop_enable,
  output logic o_write_freq_mode,
  output logic [2:0] o_decimator_shift,
  output logic o_decimator_pass,
  output logic [7:0] o_crystal_trim,
  output logic [4:0] o_hold_filter_coarse,
  output logic o_hold_filter_off,
  output logic [3:0] o_history_seconds,
  output logic o_loss_limit,
  output logic [4:0] o_bw_coarse,
  output logic [2:0] o_bw_fine,
  output logic [2:0] o_damp_coarse,
  output logic [2:0] o_damp_fine,
  output logic [4:0] o_loop_state
);

  // Overview of the bank.
  // The block holds seven configuration registers that steer the loop and
  // one read-only status word that reports the loop state and loss limit.
  // Software reaches them over a classic Wishbone slave with a registered
  // acknowledge, so every access takes exactly one wait cycle.
  // Eight-bit registers use byte lane 0 only; sixteen-bit registers use
  // lanes 0 and 1 independently, and the upper lanes are ignored.
  // Stored fields keep the raw value that software wrote; any clamping
  // happens on the configuration outputs so that read-back is faithful.
  // Reserved bits are masked on write so that they always read as zero.
  // The manual pin selection is asynchronous to the core clock and passes
  // a three-flop synchroniser with a two-sample agreement filter.
  // The loop state machine runs on the same clock as the bus and follows
  // the mode register, the reference validity and the lock timer.
  // The clock enable freezes every register, including the bus answer,
  // so a master must not expect progress while the enable is low.
  // Reset is synchronous and takes effect even while the enable is low.

  // All state of the block.
  typedef struct packed {
    logic [7:0] ref_fb;
    logic [7:0] mode;
    logic [7:0] decim;
    logic [7:0] xtal;
    logic [15:0] hold;
    logic [15:0] bw;
    logic [15:0] damp;
    logic [2:0] pin_sync;
    logic [2:0] pin_sync_b;
    logic [1:0] pins_ok;
    dpc_loop_t loop;
    logic [TIMER_W-1:0] good_time;
    logic ack;
    logic [31:0] rdata;
  } dpc_state_t;

  dpc_state_t st;
  dpc_state_t next_st;
  // Bus request that has not yet been answered.
  logic req;
  // Half lock interval, honouring the minimum timer value.
  logic [TIMER_W-1:0] half_time;
  // Read view of the register selected by the address.
  logic [31:0] rd_view;
  logic [7:0] wr8;
  logic [15:0] wr16;

  assign req = i_wb_cyc & i_wb_stb & ~st.ack;
  assign wr8 = i_wb_dat[7:0];
  assign wr16 = i_wb_dat[15:0];
  assign half_time = ((i_lock_timer < TIMER_W'(LOCK_TIMER_MIN)) ?
                      TIMER_W'(LOCK_TIMER_MIN) : i_lock_timer) >> 1;

  // Read multiplexer.
  // The view is taken from the stored registers before any write of the
  // same cycle, so a read always returns the value that was in place when
  // the request was taken.
  // The status word is built from live outputs, so it shows the loop state
  // and loss limit as they stand at the edge that takes the request.
  // Unmapped addresses read as zero and still receive an acknowledge.
  // Selects read data for the addressed register; unmapped reads zero.
  always_comb begin
    rd_view = 32'h0000_0000;
    unique case (i_wb_adr)
      ADDR_REF_FB: begin
        rd_view[7:0] = st.ref_fb;
      end
      ADDR_MODE: begin
        rd_view[7:0] = st.mode;
      end
      ADDR_DECIM: begin
        rd_view[7:0] = st.decim;
      end
      ADDR_XTAL: begin
        rd_view[7:0] = st.xtal;
      end
      ADDR_HOLD: begin
        rd_view[15:0] = st.hold;
      end
      ADDR_BW: begin
        rd_view[15:0] = st.bw;
      end
      ADDR_DAMP: begin
        rd_view[15:0] = st.damp;
      end
      ADDR_STATUS: begin
        rd_view[5:0] = {o_loss_limit, o_loop_state};
      end
      default: begin
        rd_view = 32'h0000_0000;
      end
    endcase
  end

  // Computes the next state of registers, synchronisers and loop machine.
  always_comb begin
    next_st = st;
    next_st.ack = req;
    if (req) begin
      next_st.rdata = rd_view;
    end
    // Write decode.
    // A write lands at the same edge that raises the acknowledge, so the
    // new value is visible on the outputs while the acknowledge stands.
    // Writes to the status word and unmapped addresses are answered but
    // change nothing, which keeps a stray access harmless.
    // Byte lanes 0 and 1 write the low and high byte; reserved bits are masked.
    // masked reserved bits
    if (req && i_wb_we) begin
      unique case (i_wb_adr)
        ADDR_REF_FB: begin
          if (i_wb_sel[0]) next_st.ref_fb = wr8;
        end
        ADDR_MODE: begin
          if (i_wb_sel[0]) next_st.mode = wr8;
        end
        ADDR_DECIM: begin
          if (i_wb_sel[0]) next_st.decim = wr8 & MASK_DECIM;
        end
        ADDR_XTAL: begin
          if (i_wb_sel[0]) next_st.xtal = wr8;
        end
        ADDR_HOLD: begin
          if (i_wb_sel[0]) next_st.hold[7:0] = wr16[7:0];
          if (i_wb_sel[1]) next_st.hold[15:8] = wr16[15:8];
        end
        ADDR_BW: begin
          if (i_wb_sel[0]) next_st.bw[7:0] = wr16[7:0];
          if (i_wb_sel[1]) next_st.bw[15:8] = wr16[15:8];
        end
        ADDR_DAMP: begin
          if (i_wb_sel[0]) next_st.damp[7:0] = wr16[7:0] & MASK_DAMP[7:0];
          if (i_wb_sel[1]) next_st.damp[15:8] = wr16[15:8] & MASK_DAMP[15:8];
        end
        default: begin
          next_st.ack = req;
        end
      endcase
    end
    // Pin selection passes three flops; a change counts when the last two agree.
    next_st.pin_sync = {st.pin_sync[1:0], i_ref_pins[0]};
    next_st.pin_sync_b = {st.pin_sync_b[1:0], i_ref_pins[1]};
    if (st.pin_sync[2] == st.pin_sync[1]) next_st.pins_ok[0] = st.pin_sync[2];
    if (st.pin_sync_b[2] == st.pin_sync_b[1]) next_st.pins_ok[1] = st.pin_sync_b[2];
    // Loop state machine.
    // Idle is held whenever the loop is disabled; enabling it moves the
    // loop to Acquire unless a forced state, write-frequency operation or a lost reference overrides.
    // Forced Freerun, forced Holdover and write-frequency operation win
    // over automatic operation, and write-frequency keeps the loop free.
    // In automatic operation a lost reference sends the loop to Holdover
    // or Freerun as the lost-reference bit chooses, and a valid reference
    // returns it to Acquire; Normal is only reached from Acquire.
    // The case below moves Idle to Acquire when enabled and keeps any other state;
    // the priority chain after it applies the mode and reference conditions on top.
    unique case (st.loop)
      DPC_IDLE: begin
        if (st.mode[2]) next_st.loop = DPC_ACQ;
      end
      DPC_FREE, DPC_HOLD, DPC_ACQ, DPC_NORM: begin
        next_st.loop = st.loop;
      end
    endcase
    if (!st.mode[2]) begin
      next_st.loop = DPC_IDLE;
    end else if (st.mode[1:0] == LOOP_FORCE_FREE) begin
      next_st.loop = DPC_FREE;
    end else if (st.mode[1:0] == LOOP_FORCE_HOLD) begin
      next_st.loop = DPC_HOLD;
    end else if (st.mode[1:0] == LOOP_WRITE_FREQ) begin
      next_st.loop = DPC_FREE;
    end else if (!i_ref_valid) begin
      next_st.loop = st.mode[6] ? DPC_FREE : DPC_HOLD;
    end else if (st.loop != DPC_ACQ && st.loop != DPC_NORM) begin
      next_st.loop = DPC_ACQ;
    end
    // Lock timing.
    // The counter runs only while the loop stays in Acquire with the phase
    // error below its threshold, and it advances once per timer tick.
    // Any break in the good phase clears it, so the interval must be met
    // without interruption; a timer value below the minimum is raised to it.
    // half timer in acquire
    next_st.good_time = '0;
    if (next_st.loop == DPC_ACQ && st.loop == DPC_ACQ && i_phase_ok) begin
      next_st.good_time = st.good_time;
      if (i_timer_tick) next_st.good_time = st.good_time + 1'b1;
      if (st.good_time >= half_time) next_st.loop = DPC_NORM;
    end
  end

  // State register.
  // Every register resets to its documented default, the synchronisers to
  // zero and the loop to Idle, so the loop stays off until it is enabled.
  // Only constants are loaded in the reset branch.
  // Registers the state; synchronous reset, frozen while the enable is low.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st.ref_fb <= RST_REF_FB;
      st.mode <= RST_MODE;
      st.decim <= RST_DECIM;
      st.xtal <= RST_XTAL;
      st.hold <= RST_HOLD;
      st.bw <= RST_BW;
      st.damp <= RST_DAMP;
      st.pin_sync <= 3'h0;
      st.pin_sync_b <= 3'h0;
      st.pins_ok <= 2'h0;
      st.loop <= DPC_IDLE;
      st.good_time <= '0;
      st.ack <= 1'b0;
      st.rdata <= 32'h0000_0000;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // Bus answer.
  // The acknowledge is a one-cycle pulse; it cannot repeat for the same
  // request because a raised acknowledge blocks the next take.
  // Read data stays in place until the next access is taken.
  assign o_wb_ack = st.ack;
  assign o_wb_dat = st.rdata;

  // Reference choice.
  // Policy zero uses the manual field, policy one the filtered pins, and
  // both automatic codes use the selector's result while it is valid.
  // Without a valid automatic result the manual field is used as a safe
  // fallback, so the output never points at an undefined input.
  // Reference choice by policy and manual field.
  always_comb begin
    if (st.ref_fb[7:6] == SEL_MANUAL_FIELD) begin
      o_active_ref = st.ref_fb[5:4];
    end else if (st.ref_fb[7:6] == SEL_MANUAL_PINS) begin
      o_active_ref = st.pins_ok;
    end else begin
      o_active_ref = i_auto_ref_valid ? i_auto_ref : st.ref_fb[5:4];
    end
  end

  // Configuration outputs.
  // These decode the stored registers, the trim and loss limit also using live inputs,
  // so they follow a write at the edge that acknowledges it.
  // The feedback divider runs only with internal feedback and the loop on;
  // the two unused feedback codes select neither source.
  // feedback source pick
  assign o_feedback_external = (st.ref_fb[3:2] == FB_EXTERNAL);
  assign o_feedback_divider_on = (st.ref_fb[3:2] == FB_INTERNAL) & st.mode[2];
  assign o_revertive = st.ref_fb[1];
  assign o_hitless = st.ref_fb[0];
  assign o_sync_none = (st.mode[5:4] != SYNC_GROUP0) && (st.mode[5:4] != SYNC_GROUP1);
  assign o_sync_group = st.mode[5:4];
  assign o_filter_update_off = st.mode[3];
  assign o_loop_enable = st.mode[2];
  assign o_write_freq_mode = (st.mode[1:0] == LOOP_WRITE_FREQ);
  assign o_decimator_shift = o_hitless ? st.decim[6:4] : st.decim[2:0];
  assign o_decimator_pass = (st.decim[3:0] == 4'h0);
  assign o_crystal_trim = i_modulator_ok ? st.xtal : 8'h00;
  assign o_hold_filter_coarse = (st.hold[15:11] > HOLD_COARSE_MAX) ?
                                HOLD_COARSE_MAX : st.hold[15:11];
  assign o_hold_filter_off = (st.hold[15:11] == 5'h00) | (st.hold[10:8] == 3'h0);
  assign o_history_seconds = (st.hold[7:4] > HISTORY_MAX) ? HISTORY_MAX : st.hold[7:4];
  assign o_loss_limit = (i_loss_count > st.hold[3:0]);
  // Filter settings.
  // The Acquire set drives the loop only while the loop is in Acquire and
  // the automatic switch bit is set; otherwise the Normal set is used.
  // Switching happens at the edge that moves the loop out of Acquire or clears the switch bit.
  // filter set choice
  always_comb begin
    if (st.mode[7] && st.loop == DPC_ACQ) begin
      o_bw_coarse = st.bw[15:11];
      o_bw_fine = st.bw[10:8];
      o_damp_coarse = st.damp[13:11];
      o_damp_fine = st.damp[10:8];
    end else begin
      o_bw_coarse = st.bw[7:3];
      o_bw_fine = st.bw[2:0];
      o_damp_coarse = st.damp[5:3];
      o_damp_fine = st.damp[2:0];
    end
  end
  assign o_loop_state = st.loop;

endmodule
`default_nettype wire

// File: hdl/dpc_pkg.sv
// Package with register map, field layout, reset values and loop states for the DPLL config bank.
package dpc_pkg;
  // Register byte addresses on the Wishbone bus.
  localparam logic [4:0] ADDR_REF_FB = 5'h00;
  localparam logic [4:0] ADDR_MODE = 5'h04;
  localparam logic [4:0] ADDR_DECIM = 5'h08;
  localparam logic [4:0] ADDR_XTAL = 5'h0C;
  localparam logic [4:0] ADDR_HOLD = 5'h10;
  localparam logic [4:0] ADDR_BW = 5'h14;
  localparam logic [4:0] ADDR_DAMP = 5'h18;
  localparam logic [4:0] ADDR_STATUS = 5'h1C;
  // Reset values of each register.
  localparam logic [7:0] RST_REF_FB = 8'h04;
  localparam logic [7:0] RST_MODE = 8'h81;
  localparam logic [7:0] RST_DECIM = 8'h36;
  localparam logic [7:0] RST_XTAL = 8'h00;
  localparam logic [15:0] RST_HOLD = 16'h3800;
  localparam logic [15:0] RST_BW = 16'h7058;
  localparam logic [15:0] RST_DAMP = 16'h2900;
  // Writable bit masks; reserved bits stay zero.
  localparam logic [7:0] MASK_DECIM = 8'h7F;
  localparam logic [15:0] MASK_DAMP = 16'h3F3F;
  // Field codes.
  localparam logic [1:0] SEL_MANUAL_FIELD = 2'h0;
  localparam logic [1:0] SEL_MANUAL_PINS = 2'h1;
  localparam logic [1:0] FB_EXTERNAL = 2'h0;
  localparam logic [1:0] FB_INTERNAL = 2'h1;
  localparam logic [1:0] LOOP_FORCE_FREE = 2'h0;
  localparam logic [1:0] LOOP_AUTO = 2'h1;
  localparam logic [1:0] LOOP_FORCE_HOLD = 2'h2;
  localparam logic [1:0] LOOP_WRITE_FREQ = 2'h3;
  localparam logic [1:0] SYNC_GROUP0 = 2'h0;
  localparam logic [1:0] SYNC_GROUP1 = 2'h1;
  localparam logic [4:0] HOLD_COARSE_MAX = 5'd20;
  localparam logic [3:0] HISTORY_MAX = 4'hA;
  localparam logic [15:0] LOCK_TIMER_MIN = 16'h0002;
  // Loop state machine codes, one-hot.
  typedef enum logic [4:0] {
    DPC_IDLE = 5'b00001,
    DPC_FREE = 5'b00010,
    DPC_ACQ = 5'b00100,
    DPC_NORM = 5'b01000,
    DPC_HOLD = 5'b10000
  } dpc_loop_t;
endpackage

// File: verification/dpc_regs_props.sv
// Checker for bus handshake and configuration output relations.
`timescale 1ns/1ps
`default_nettype none
module dpc_regs_props (
  // Clock, reset and bus.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic o_wb_ack,
  // Loop side.
  input wire logic i_modulator_ok,
  input wire logic o_feedback_external,
  input wire logic o_feedback_divider_on,
  input wire logic o_loop_enable,
  input wire logic o_revertive,
  input wire logic [1:0] o_sync_group,
  input wire logic o_sync_none,
  input wire logic [7:0] o_crystal_trim,
  input wire logic [4:0] o_hold_filter_coarse,
  input wire logic [3:0] o_history_seconds,
  input wire logic [4:0] o_loop_state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // A taken request and the single answer it earns.
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en;
  endsequence
  sequence s_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  a_ack_pulse: assert property (s_req |=> s_pulse)
    else $error("ack missing or too long");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_cfg_hold: assert property (!(i_wb_cyc && i_wb_stb && i_wb_we) |=> $stable(o_revertive))
    else $error("revertive bit moved without write");
  a_div_on: assert property (o_feedback_divider_on == (!o_feedback_external && o_loop_enable))
    else $error("feedback divider state wrong");
  a_sync_none: assert property (!o_sync_none |-> !o_sync_group[1])
    else $error("sync group code 2 or 3 not none");
  a_trim_gate: assert property (!i_modulator_ok |-> o_crystal_trim == 8'h00)
    else $error("trim applied without modulator order");
  a_hold_clamp: assert property (o_hold_filter_coarse <= 5'h14)
    else $error("hold coarse above clamp");
  a_hist_clamp: assert property (o_history_seconds <= 4'hA)
    else $error("history above ten seconds");
  a_idle_off: assert property (i_clk_en && !o_loop_enable |=> o_loop_state == 5'h01)
    else $error("loop not idle while disabled");
  a_state_hot: assert property ($onehot(o_loop_state))
    else $error("loop state not one-hot");
endmodule
`default_nettype wire

// File: verification/dpc_regs_bench.sv
// Self-checking bench for the loop configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module dpc_regs_bench;
  import dpc_pkg::*;
  // Bus and loop stimulus.
  logic i_core_clk, i_rst_n, i_clk_en, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [4:0] i_wb_adr;
  logic [3:0] i_wb_sel, i_loss_count;
  logic [31:0] i_wb_dat, o_wb_dat, rdat;
  logic [1:0] i_ref_pins, i_auto_ref, o_active_ref, o_sync_group;
  logic i_auto_ref_valid, i_ref_valid, i_phase_ok, i_timer_tick, i_modulator_ok;
  logic [15:0] i_lock_timer;
  // Observed outputs.
  logic o_wb_ack, o_feedback_external, o_feedback_divider_on, o_revertive, o_hitless;
  logic o_sync_none, o_filter_update_off, o_loop_enable, o_write_freq_mode;
  logic o_decimator_pass, o_hold_filter_off, o_loss_limit;
  logic [2:0] o_decimator_shift, o_bw_fine, o_damp_coarse, o_damp_fine;
  logic [7:0] o_crystal_trim;
  logic [4:0] o_hold_filter_coarse, o_bw_coarse, o_loop_state;
  logic [3:0] o_history_seconds;
  int errors, n_tests, cycles;
  // Mode bytes and the loop state each must reach.
  logic [7:0] mt [5] = '{8'h84, 8'h86, 8'h87, 8'h85, 8'hC5};
  logic [4:0] st [5] = '{5'h02, 5'h10, 5'h02, 5'h10, 5'h02};
  dpc_regs #(.TIMER_W(16)) dpc_regs_inst (.*);
  // Free-running clock.
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One classic cycle; read data is taken at the edge that sees ack.
  task automatic bus(input logic we, input logic [4:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    @(posedge i_core_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'b11, we};
    {i_wb_adr, i_wb_sel, i_wb_dat} <= {a, s, d};
    do @(posedge i_core_clk); while (o_wb_ack !== 1'b1);
    rdat = o_wb_dat;
    {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'h3, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 4'hF, 32'h0);
    check(rdat, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // Hang guard.
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    {i_rst_n, i_clk_en, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel} = 14'h1000;
    {i_wb_dat, i_ref_pins, i_auto_ref, i_auto_ref_valid, i_ref_valid} = '0;
    {i_phase_ok, i_timer_tick, i_modulator_ok, i_loss_count, i_lock_timer} = 23'h100000;
    wait_n(8);
    i_rst_n <= 1'b1;
    rd(ADDR_REF_FB, {24'h0, RST_REF_FB});
    rd(ADDR_MODE, {24'h0, RST_MODE});
    rd(ADDR_DECIM, {24'h0, RST_DECIM});
    rd(ADDR_XTAL, {24'h0, RST_XTAL});
    rd(ADDR_HOLD, {16'h0, RST_HOLD});
    rd(ADDR_BW, {16'h0, RST_BW});
    rd(ADDR_DAMP, {16'h0, RST_DAMP});
    rd(5'h1E, 32'h0);
    // Reserved bits and a single byte lane.
    wr(ADDR_DECIM, 32'hFFFF);
    rd(ADDR_DECIM, {24'h0, MASK_DECIM});
    wr(ADDR_DAMP, 32'hFFFF);
    rd(ADDR_DAMP, {16'h0, MASK_DAMP});
    bus(1'b1, ADDR_BW, 4'h1, 32'hFFFF);
    rd(ADDR_BW, 32'h70FF);
    // Decimator pass-through and the hitless shift.
    // decimator written while the converter is held off
    wr(ADDR_DECIM, 32'h50);
    check(32'(o_decimator_pass), 32'h1);
    check(32'(o_decimator_shift), 32'h0);
    wr(ADDR_REF_FB, 32'h05);
    check(32'(o_decimator_shift), 32'h5);
    check(32'(o_hitless), 32'h1);
    check(32'(o_revertive), 32'h0);
    // Holdover clamps and the loss limit on both sides of the threshold.
    i_loss_count <= 4'h4;
    wr(ADDR_HOLD, 32'hF8B3);
    check(32'(o_hold_filter_coarse), 32'h14);
    check(32'(o_history_seconds), 32'hA);
    check(32'(o_hold_filter_off), 32'h1);
    check(32'(o_loss_limit), 32'h1);
    i_loss_count <= 4'h3;
    wait_n(1);
    check(32'(o_loss_limit), 32'h0);
    // Trim passes only with modulator order above zero.
    wr(ADDR_XTAL, 32'h80);
    check(32'(o_crystal_trim), 32'h80);
    // update disable set around the modulator order change
    wr(ADDR_MODE, 32'h39);
    check(32'(o_filter_update_off), 32'h1);
    check(32'(o_sync_none), 32'h1);
    i_modulator_ok <= 1'b0;
    wait_n(1);
    check(32'(o_crystal_trim), 32'h0);
    wr(ADDR_MODE, 32'h13);
    check(32'(o_filter_update_off), 32'h0);
    check(32'(o_sync_group), 32'h1);
    check(32'(o_sync_none), 32'h0);
    check(32'(o_write_freq_mode), 32'h1);
    // Manual field, pins and automatic selection.
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_REF_FB, 32'(i * 16));
      check(32'(o_active_ref), 32'(i));
    end
    check(32'(o_feedback_external), 32'h1);
    // external feedback chosen; divider left idle by software
    check(32'(o_feedback_divider_on), 32'h0);
    i_ref_pins <= 2'h3;
    wr(ADDR_REF_FB, 32'h40);
    wait_n(5);
    check(32'(o_active_ref), 32'h3);
    {i_auto_ref_valid, i_auto_ref} <= 3'b101;
    for (int m = 2; m < 4; m++) begin
      wr(ADDR_REF_FB, 32'(m * 64));
      check(32'(o_active_ref), 32'h1);
    end
    // Forced states and loss of reference.
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_MODE, 32'(mt[k]));
      wait_n(3);
      check(32'(o_loop_state), 32'(st[k]));
    end
    // Acquire filter choice, then one tick at the minimum timer.
    i_ref_valid <= 1'b1;
    wr(ADDR_MODE, 32'h85);
    wait_n(3);
    check(32'(o_loop_state), 32'h04);
    check(32'(o_bw_coarse), 32'h0E);
    check(32'(o_damp_coarse), 32'h7);
    check(32'(o_loop_enable), 32'h1);
    wr(ADDR_MODE, 32'h05);
    check(32'(o_bw_coarse), 32'h1F);
    i_phase_ok <= 1'b1;
    wait_n(3);
    check(32'(o_loop_state), 32'h04);
    i_timer_tick <= 1'b1;
    wait_n(1);
    i_timer_tick <= 1'b0;
    wait_n(3);
    check(32'(o_loop_state), 32'h08);
    wr(ADDR_MODE, 32'h01);
    wait_n(3);
    check(32'(o_loop_state), 32'h01);
    finish_test();
  end
endmodule
bind dpc_regs dpc_regs_props dpc_regs_props_inst (.*);
`default_nettype wire
